// [hdl/pacc_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pacc_params.svh"
module pacc_top (
	// System
	input wire logic clock,
	input wire logic reset,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output pacc_pkg::pacc_word_t avs_readdata,
	output logic avs_waitrequest,
	// Digitised input difference in LSB units
	input wire logic signed [10:0] analog_level,
	// Test selects
	input wire logic digital_test_select,
	input wire logic flash_test_select,
	// Analog section controls
	output logic converter_powered,
	output logic ref_internal,
	output logic cm_buffer_on,
	output logic bias_internal,
	// Result stream
	output pacc_pkg::pacc_code_t result_code,
	output logic result_valid,
	output pacc_pkg::pacc_mode_e op_mode
);
	import pacc_pkg::*;

	// Mode from the four enables
	function automatic pacc_mode_e decode_mode(input logic [3:0] c);
		pacc_mode_e m;
		m = PACC_MODE_BAD;
		if (!c[`PACC_CTRL_CONV]) begin
			m = PACC_MODE_OFF;
		end else begin
			case ({c[`PACC_CTRL_REF], c[`PACC_CTRL_CM], c[`PACC_CTRL_BIAS]})
				3'h7: m = PACC_MODE_1;
				3'h5: m = PACC_MODE_2;
				3'h1: m = PACC_MODE_3;
				3'h6: m = PACC_MODE_4;
				3'h4: m = PACC_MODE_5;
				3'h0: m = PACC_MODE_6;
				default: m = PACC_MODE_BAD;
			endcase
		end
		return m;
	endfunction

	// Saturating offset binary conversion
	function automatic pacc_code_t to_code(input logic signed [10:0] lvl);
		logic signed [11:0] biased;
		pacc_code_t c;
		biased = $signed({lvl[10], lvl}) + 12'sh200;
		if (biased < 12'sh000) begin
			c = `PACC_MIN_CODE;
		end else if (biased > 12'sh3ff) begin
			c = `PACC_MAX_CODE;
		end else begin
			c = biased[9:0];
		end
		return c;
	endfunction

	logic [3:0] ctrl_reg;
	logic wait_reg;
	pacc_word_t readdata_reg;
	pacc_mode_e mode_now;
	logic active;
	pacc_code_t sample_now;
	pacc_pwr_e pwr_reg;
	pacc_pwr_e pwr_next;
	logic [4:0] wake_count_reg;
	logic [31:0] sample_count_reg;
	pacc_code_t stage_reg [`PACC_LATENCY];
	logic stage_valid_reg [`PACC_LATENCY];
	logic [5:0] age_reg;

	assign mode_now = decode_mode(ctrl_reg);
	assign active = (mode_now != PACC_MODE_OFF) && (mode_now != PACC_MODE_BAD);
	assign sample_now = to_code(analog_level);

	// Bus handshake, one wait cycle per access
	always_ff @(posedge clock) begin
		if (reset) begin
			wait_reg <= 1'b1;
		end else if ((avs_read || avs_write) && wait_reg) begin
			wait_reg <= 1'b0;
		end else begin
			wait_reg <= 1'b1;
		end
	end

	// Read data captured while waiting
	always_ff @(posedge clock) begin
		if (reset) begin
			readdata_reg <= 32'h0000_0000;
		end else if (avs_read && wait_reg) begin
			readdata_reg <= 32'h0000_0000;
			case (avs_address[3:2])
				`PACC_REG_CTRL: begin
					readdata_reg[3:0] <= ctrl_reg;
				end
				`PACC_REG_STATUS: begin
					readdata_reg[`PACC_STAT_MODE_LSB +: 3] <= mode_now;
					readdata_reg[`PACC_STAT_VALID] <= result_valid;
					readdata_reg[`PACC_STAT_WAKING] <= (pwr_reg == PACC_PWR_WAKE);
					readdata_reg[`PACC_STAT_COUNT_LSB +: 5] <= wake_count_reg;
					readdata_reg[`PACC_STAT_DGT] <= digital_test_select;
					readdata_reg[`PACC_STAT_FLASH] <= flash_test_select;
				end
				`PACC_REG_DATA: begin
					readdata_reg[9:0] <= result_code;
				end
				`PACC_REG_SAMPLES: begin
					readdata_reg <= sample_count_reg;
				end
				default: begin
					readdata_reg <= 32'h0000_0000;
				end
			endcase
		end
	end

	// Control register write
	always_ff @(posedge clock) begin
		if (reset) begin
			ctrl_reg <= `PACC_CTRL_RESET;
		end else if (avs_write && !wait_reg && avs_byteenable[0]
			&& (avs_address[3:2] == `PACC_REG_CTRL)) begin
			ctrl_reg <= avs_writedata[3:0];
		end
	end

	// Analog section controls and mode
	always_ff @(posedge clock) begin
		if (reset) begin
			converter_powered <= 1'b0;
			ref_internal <= 1'b0;
			cm_buffer_on <= 1'b0;
			bias_internal <= 1'b0;
			op_mode <= PACC_MODE_OFF;
		end else begin
			converter_powered <= active;
			ref_internal <= active && ctrl_reg[`PACC_CTRL_REF];
			cm_buffer_on <= active && ctrl_reg[`PACC_CTRL_CM];
			bias_internal <= active && ctrl_reg[`PACC_CTRL_BIAS];
			op_mode <= mode_now;
		end
	end

	// Power state next value
	always_comb begin
		pwr_next = pwr_reg;
		case (pwr_reg)
			PACC_PWR_DOWN: begin
				if (active) begin
					pwr_next = PACC_PWR_WAKE;
				end
			end
			PACC_PWR_WAKE: begin
				if (!active) begin
					pwr_next = PACC_PWR_DOWN;
				end else if (wake_count_reg == 5'(`PACC_POWERUP_CYCLES - 1)) begin
					pwr_next = PACC_PWR_RUN;
				end
			end
			PACC_PWR_RUN: begin
				if (!active) begin
					pwr_next = PACC_PWR_DOWN;
				end
			end
			default: begin
				pwr_next = PACC_PWR_DOWN;
			end
		endcase
	end

	// Power state on the conversion edge
	always_ff @(negedge clock) begin
		if (reset) begin
			pwr_reg <= PACC_PWR_DOWN;
		end else begin
			pwr_reg <= pwr_next;
		end
	end

	// Wake delay counter
	always_ff @(negedge clock) begin
		if (reset || (pwr_reg != PACC_PWR_WAKE) || !active) begin
			wake_count_reg <= 5'h00;
		end else begin
			wake_count_reg <= wake_count_reg + 5'h01;
		end
	end

	// Sample counter
	always_ff @(negedge clock) begin
		if (reset) begin
			sample_count_reg <= 32'h0000_0000;
		end else if (active) begin
			sample_count_reg <= sample_count_reg + 32'h0000_0001;
		end
	end

	// Pipeline input stage
	always_ff @(negedge clock) begin
		stage_reg[0] <= sample_now;
	end

	always_ff @(negedge clock) begin
		if (reset || !active) begin
			stage_valid_reg[0] <= 1'b0;
		end else begin
			stage_valid_reg[0] <= (pwr_reg == PACC_PWR_RUN);
		end
	end

	// Pipeline delay stages
	genvar gi;
	generate
		for (gi = 1; gi < `PACC_LATENCY; gi++) begin : g_stage
			always_ff @(negedge clock) begin
				stage_reg[gi] <= stage_reg[gi - 1];
			end
			always_ff @(negedge clock) begin
				if (reset || !active) begin
					stage_valid_reg[gi] <= 1'b0;
				end else begin
					stage_valid_reg[gi] <= stage_valid_reg[gi - 1];
				end
			end
		end
	endgenerate

	// Output register
	always_ff @(negedge clock) begin
		if (reset) begin
			result_code <= `PACC_MID_CODE;
		end else begin
			result_code <= stage_reg[`PACC_LATENCY - 1];
		end
	end

	always_ff @(negedge clock) begin
		if (reset || !active) begin
			result_valid <= 1'b0;
		end else begin
			result_valid <= stage_valid_reg[`PACC_LATENCY - 1];
		end
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata = readdata_reg;

	// Edges since wake, for checking
	always_ff @(negedge clock) begin
		if (reset || !active) begin
			age_reg <= 6'h00;
		end else if (age_reg != 6'h3f) begin
			age_reg <= age_reg + 6'h01;
		end
	end

	sequence s_sampled;
		!reset;
	endsequence

	sequence s_loaded;
		##6 (result_code == $past(sample_now, 6));
	endsequence

	property p_latency;
		@(negedge clock) disable iff (reset)
		s_sampled |-> s_loaded;
	endproperty
	a_latency: assert property (p_latency) else $error("result not at latency");

	property p_powerdown;
		@(posedge clock) disable iff (reset)
		!ctrl_reg[`PACC_CTRL_CONV] |=> (op_mode == PACC_MODE_OFF) && !converter_powered;
	endproperty
	a_powerdown: assert property (p_powerdown) else $error("no power-down");

	property p_mode1;
		@(posedge clock) disable iff (reset)
		(ctrl_reg == 4'hf) |=> (op_mode == PACC_MODE_1);
	endproperty
	a_mode1: assert property (p_mode1) else $error("mode 1 decode wrong");

	property p_mode6;
		@(posedge clock) disable iff (reset)
		(ctrl_reg == 4'h1) |=> (op_mode == PACC_MODE_6) && !ref_internal && !bias_internal;
	endproperty
	a_mode6: assert property (p_mode6) else $error("mode 6 decode wrong");

	property p_cm_off;
		@(posedge clock) disable iff (reset)
		!ctrl_reg[`PACC_CTRL_CM] |=> !cm_buffer_on;
	endproperty
	a_cm_off: assert property (p_cm_off) else $error("buffer not off");

	property p_bias;
		@(posedge clock) disable iff (reset)
		(ctrl_reg == 4'hb) |=> bias_internal && ref_internal;
	endproperty
	a_bias: assert property (p_bias) else $error("bias not internal");

	property p_valid_age;
		@(negedge clock) disable iff (reset)
		result_valid |-> (age_reg >= 6'(`PACC_VALID_AGE));
	endproperty
	a_valid_age: assert property (p_valid_age) else $error("valid too early");

	property p_valid_arrives;
		@(negedge clock) disable iff (reset)
		(active && age_reg == 6'h00) ##1 (active [*8]) |-> !result_valid;
	endproperty
	a_valid_arrives: assert property (p_valid_arrives) else $error("valid during wake");

	property p_extremes;
		@(negedge clock) disable iff (reset)
		(analog_level <= -11'sd512) |-> (sample_now == 10'h000);
	endproperty
	a_extremes: assert property (p_extremes) else $error("bad negative full scale");

	property p_top;
		@(negedge clock) disable iff (reset)
		(analog_level >= 11'sd511) |-> (sample_now == 10'h3ff);
	endproperty
	a_top: assert property (p_top) else $error("bad positive full scale");

	property p_rate;
		@(negedge clock) disable iff (reset)
		active |=> (sample_count_reg == $past(sample_count_reg) + 32'h0000_0001);
	endproperty
	a_rate: assert property (p_rate) else $error("sample count skipped");

	property p_one_wait;
		@(posedge clock) disable iff (reset)
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("waitrequest low twice");
endmodule // pacc_top
`default_nettype wire

// [pkg/pacc_params.svh]
`ifndef PACC_PARAMS_SVH
`define PACC_PARAMS_SVH

`define PACC_CLK_PERIOD_NS 10
`define PACC_CODE_W 10
`define PACC_LATENCY 5
`define PACC_POWERUP_CYCLES 20
`define PACC_VALID_AGE 25
`define PACC_MID_CODE 10'h200
`define PACC_MAX_CODE 10'h3ff
`define PACC_MIN_CODE 10'h000

`define PACC_REG_CTRL 2'h0
`define PACC_REG_STATUS 2'h1
`define PACC_REG_DATA 2'h2
`define PACC_REG_SAMPLES 2'h3

`define PACC_CTRL_CONV 0
`define PACC_CTRL_REF 1
`define PACC_CTRL_CM 2
`define PACC_CTRL_BIAS 3
`define PACC_CTRL_RESET 4'he

`define PACC_STAT_MODE_LSB 0
`define PACC_STAT_VALID 4
`define PACC_STAT_WAKING 5
`define PACC_STAT_COUNT_LSB 8
`define PACC_STAT_DGT 16
`define PACC_STAT_FLASH 17
`endif

// [pkg/pacc_pkg.sv]
`default_nettype none
package pacc_pkg;
	typedef enum logic [2:0] {
		PACC_MODE_OFF,
		PACC_MODE_1,
		PACC_MODE_2,
		PACC_MODE_3,
		PACC_MODE_4,
		PACC_MODE_5,
		PACC_MODE_6,
		PACC_MODE_BAD
	} pacc_mode_e;
	typedef enum logic [1:0] {
		PACC_PWR_DOWN,
		PACC_PWR_WAKE,
		PACC_PWR_RUN
	} pacc_pwr_e;
	typedef logic [9:0] pacc_code_t;
	typedef logic [31:0] pacc_word_t;
endpackage
`default_nettype wire

// [bench/pacc_capture.sv]
`timescale 1ns/10ps
`default_nettype none
module pacc_capture (
	// System
	input wire logic clock,
	input wire logic reset,
	// Result stream
	input wire pacc_pkg::pacc_code_t result_code,
	input wire logic result_valid,
	// Test selects
	output logic digital_test_select,
	output logic flash_test_select,
	// Captured word
	output pacc_pkg::pacc_code_t last_code_reg
);
	import pacc_pkg::*;
	assign digital_test_select = 1'b0;
	assign flash_test_select = 1'b1;
	always_ff @(posedge clock) begin
		if (reset) begin
			last_code_reg <= 10'h200;
		end else if (result_valid) begin
			last_code_reg <= result_code;
		end
	end
endmodule // pacc_capture
`default_nettype wire

// [bench/tb_pipelined_adc_control_output.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pacc_params.svh"
module tb_pipelined_adc_control_output;
	import pacc_pkg::*;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf;
	pacc_word_t avs_readdata;
	logic avs_waitrequest;
	logic signed [10:0] analog_level = 11'h064;
	logic digital_test_select, flash_test_select;
	logic converter_powered, ref_internal, cm_buffer_on, bias_internal, result_valid;
	pacc_code_t result_code, cap_code;
	pacc_mode_e op_mode;
	int num_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int t_take, t1, n;
	logic [31:0] q, s1;
	logic act;
	// Control rows and the mode each gives
	logic [3:0] row_ctrl [10] = '{4'hf, 4'hb, 4'h9, 4'h7, 4'h3, 4'h1, 4'hd, 4'h5, 4'h0, 4'he};
	logic [2:0] row_mode [10] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h7, 3'h0, 3'h0};
	// Input levels and the codes they give
	logic [10:0] lv_in [12] = '{11'h000, 11'h7ff, 11'h001, 11'h1ff, 11'h200, 11'h258,
		11'h601, 11'h600, 11'h5a8, 11'h400, 11'h3ff, 11'h025};
	logic [9:0] lv_code [12] = '{10'h200, 10'h1ff, 10'h201, 10'h3ff, 10'h3ff, 10'h3ff,
		10'h001, 10'h000, 10'h000, 10'h000, 10'h3ff, 10'h225};

	always #(`PACC_CLK_PERIOD_NS / 2) clock = ~clock;
	always @(posedge clock) cyc <= cyc + 1;

	pacc_top pacc_top_i (.clock(clock), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .analog_level(analog_level),
		.digital_test_select(digital_test_select), .flash_test_select(flash_test_select),
		.converter_powered(converter_powered), .ref_internal(ref_internal),
		.cm_buffer_on(cm_buffer_on), .bias_internal(bias_internal),
		.result_code(result_code), .result_valid(result_valid), .op_mode(op_mode));
	pacc_capture pacc_capture_i (.clock(clock), .reset(reset), .result_code(result_code),
		.result_valid(result_valid), .digital_test_select(digital_test_select),
		.flash_test_select(flash_test_select), .last_code_reg(cap_code));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int k;
		k = 0;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge clock);
			k++;
		end while (avs_waitrequest !== 1'b0);
		chk("wait cycles", 32'h2, k);
		r = avs_readdata;
		t_take = cyc;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clock);
		chk("reset", {17'h0, 5'h10, 10'h200},
			{17'h0, avs_waitrequest, result_valid, op_mode, result_code});
		chk("readdata", 32'h0, avs_readdata);
		reset <= 1'b0;
		bus(1'b0, 4'h0, 32'h0, q);
		chk("ctrl", 32'he, q);
		for (int i = 0; i < 10; i++) begin
			bus(1'b1, 4'h0, {28'h0, row_ctrl[i]}, q);
			repeat (3) @(posedge clock);
			act = row_mode[i] != 3'h0 && row_mode[i] != 3'h7;
			chk("mode", {29'h0, row_mode[i]}, {29'h0, op_mode});
			chk("outs", {28'h0, row_ctrl[i][3:1] & {3{act}}, act}, {28'h0, bias_internal,
				cm_buffer_on, ref_internal, converter_powered});
			bus(1'b0, 4'h4, 32'h0, q);
			chk("status", {14'h0, 2'h2, 13'h0, row_mode[i]},
				{14'h0, q[17:16], 13'h0, q[2:0]});
		end
		bus(1'b1, 4'h4, 32'hf, q);
		avs_byteenable <= 4'h0;
		bus(1'b1, 4'h0, 32'hf, q);
		avs_byteenable <= 4'hf;
		bus(1'b0, 4'h0, 32'h0, q);
		chk("ctrl", 32'he, q);
		bus(1'b1, 4'h0, 32'hf, q);
		n = 0;
		while (result_valid !== 1'b1 && n < 40) begin
			@(posedge clock);
			n++;
		end
		chk("wake", 32'h1, {31'h0, n >= 26 && n <= 29});
		for (int j = 0; j < 18; j++) begin
			@(posedge clock);
			if (j >= 6) begin
				chk("code", {22'h0, lv_code[j - 6]}, {22'h0, result_code});
				chk("valid", 32'h1, {31'h0, result_valid});
			end
			if (j < 12) begin
				analog_level <= lv_in[j];
			end
		end
		bus(1'b0, 4'hc, 32'h0, q);
		s1 = q;
		t1 = t_take;
		repeat (10) @(posedge clock);
		bus(1'b0, 4'hc, 32'h0, q);
		chk("samples", 32'(t_take - t1), q - s1);
		bus(1'b0, 4'h8, 32'h0, q);
		chk("data", 32'h225, q);
		chk("captured", 32'h225, {22'h0, cap_code});
		bus(1'b1, 4'h0, 32'he, q);
		repeat (3) @(posedge clock);
		chk("off", 32'h0, {28'h0, result_valid, op_mode});
		// Wake again, then reset in mid-run
		bus(1'b1, 4'h0, 32'hf, q);
		bus(1'b0, 4'h4, 32'h0, q);
		chk("waking", 32'h21, {26'h0, q[5:0]});
		repeat (40) @(posedge clock);
		bus(1'b0, 4'h4, 32'h0, q);
		chk("running", 32'h11, {26'h0, q[5:0]});
		chk("code", 32'h225, {22'h0, result_code});
		reset <= 1'b1;
		repeat (3) @(posedge clock);
		chk("reset", {17'h0, 5'h10, 10'h200},
			{17'h0, avs_waitrequest, result_valid, op_mode, result_code});
		chk("outs", 32'h0, {28'h0, bias_internal, cm_buffer_on, ref_internal,
			converter_powered});
		reset <= 1'b0;
		bus(1'b0, 4'h0, 32'h0, q);
		chk("ctrl", 32'he, q);
		tally_and_finish();
	end

	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		tally_and_finish();
	end
endmodule // tb_pipelined_adc_control_output
`default_nettype wire
